/* rtl/smc_pkg.sv */
// Package of constants and types for the sleep-mode clock controller
package smc_pkg;

	// ------------------------------------------------------------
	// Sleep kind encodings
	// ------------------------------------------------------------
	localparam logic [2:0] KIND_IDLE     = 3'h0;
	localparam logic [2:0] KIND_QUIET    = 3'h1;
	localparam logic [2:0] KIND_PWR_DOWN = 3'h2;
	localparam logic [2:0] KIND_PWR_SAVE = 3'h3;
	localparam logic [2:0] KIND_STANDBY  = 3'h6;
	localparam logic [2:0] KIND_EXT_STBY = 3'h7;

	// ------------------------------------------------------------
	// Wake source vector bit positions
	// ------------------------------------------------------------
	localparam int WAKE_W        = 10;
	localparam int WK_LINE0_EDGE = 0;
	localparam int WK_LINE0_LVL  = 1;
	localparam int WK_LINE1_EDGE = 2;
	localparam int WK_LINE1_LVL  = 3;
	localparam int WK_LINE2      = 4;
	localparam int WK_TWO_WIRE   = 5;
	localparam int WK_TIMER_TWO  = 6;
	localparam int WK_SELF_PROG  = 7;
	localparam int WK_CONVERTER  = 8;
	localparam int WK_COMPARATOR = 9;

	// ------------------------------------------------------------
	// Timing counts in clock cycles
	// ------------------------------------------------------------
	localparam logic [7:0] HALT_EXTRA_CYC  = 8'h04;
	localparam logic [7:0] STBY_WAKE_CYC   = 8'h06;
	localparam logic [7:0] START_UP_DFLT   = 8'h06;

	// Clock gate vector positions
	localparam int GATE_W    = 5;
	localparam int G_CPU     = 0;
	localparam int G_FLASH   = 1;
	localparam int G_IO      = 2;
	localparam int G_CONV    = 3;
	localparam int G_CRYSTAL = 4;

	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_SLEEP = 4'h2,
		ST_START = 4'h4,
		ST_HALT  = 4'h8
	} smc_state_t;

endpackage

/* rtl/smc_sleep_ctrl.sv */
// Sleep-mode controller: halt entry, clock gating and wake-up sequencing
`timescale 1ns/1ns
module smc_sleep_ctrl #(
	parameter logic [7:0] START_UP_CYC = smc_pkg::START_UP_DFLT
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        sleep_permit_bit,
	input  wire logic [2:0]                  sleep_kind_field,
	input  wire logic                        comparator_off_bit,
	input  wire logic                        async_timer_enable_bit,
	input  wire logic                        crystal_source,
	input  wire logic                        converter_enable,
	input  wire logic                        halt_instr,
	input  wire logic                        any_reset,
	input  wire logic [smc_pkg::WAKE_W-1:0] wake_req,
	output logic [smc_pkg::GATE_W-1:0]      clk_run,
	output logic                             osc_run,
	output logic                             timer_osc_run,
	output logic                             comparator_on,
	output logic                             conv_start,
	output logic                             core_hold,
	output logic                             irq_go,
	output logic                             reset_vector,
	output logic                             asleep,
	output logic [2:0]                       active_kind
);
	import smc_pkg::*;

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		smc_state_t           st;
		logic [2:0]           kind;
		logic [7:0]           cnt;
		logic                 by_reset;
		logic [GATE_W-1:0]    clk_run;
		logic                 osc_run;
		logic                 timer_osc_run;
		logic                 comparator_on;
		logic                 conv_start;
		logic                 core_hold;
		logic                 irq_go;
		logic                 reset_vector;
		logic                 asleep;
	} smc_regs_t;

	smc_regs_t r;
	smc_regs_t next_r;
	logic      wake_hit;

	smc_wake_filter u_filter (
		.sleep_kind_field       (r.kind),
		.async_timer_enable_bit (async_timer_enable_bit),
		.comparator_off_bit     (comparator_off_bit),
		.wake_req               (wake_req),
		.wake_hit               (wake_hit)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// A standby kind without a crystal is not offered, and the halt is refused
	// Unused codes are refused too, so a stray value never stops any clock
	function automatic logic kind_legal(input logic [2:0] k, input logic xtal);
		case (k)
			KIND_IDLE, KIND_QUIET, KIND_PWR_DOWN, KIND_PWR_SAVE: kind_legal = 1'b1;
			KIND_STANDBY, KIND_EXT_STBY:                         kind_legal = xtal;
			default:                                             kind_legal = 1'b0;
		endcase
	endfunction

	function automatic logic is_standby(input logic [2:0] k);
		is_standby = (k == KIND_STANDBY) || (k == KIND_EXT_STBY);
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_r            = r;
		next_r.conv_start = 1'b0;
		next_r.irq_go     = 1'b0;
		case (r.st)
			ST_RUN: begin
				next_r.clk_run       = '1;
				next_r.osc_run       = 1'b1;
				next_r.timer_osc_run = async_timer_enable_bit;
				next_r.comparator_on = ~comparator_off_bit;
				next_r.core_hold     = 1'b0;
				next_r.asleep        = 1'b0;
				next_r.reset_vector  = 1'b0;
				// Halt without permit falls through as a no-op
				if (halt_instr && sleep_permit_bit &&
				    kind_legal(sleep_kind_field, crystal_source)) begin
					next_r.st     = ST_SLEEP;
					next_r.kind   = sleep_kind_field;
					next_r.asleep = 1'b1;
					next_r.core_hold = 1'b1;
					next_r.clk_run[G_CPU]   = 1'b0;
					next_r.clk_run[G_FLASH] = 1'b0;
					case (sleep_kind_field)
						KIND_IDLE: begin
							next_r.conv_start = converter_enable;
						end
						KIND_QUIET: begin
							next_r.clk_run[G_IO] = 1'b0;
							next_r.comparator_on = 1'b0;
							next_r.conv_start    = converter_enable;
						end
						default: begin
							// Deep kinds: all clocks stop but the crystal clock in power-save and extended standby with the async timer on
							next_r.clk_run       = '0;
							next_r.comparator_on = 1'b0;
							next_r.clk_run[G_CRYSTAL] = async_timer_enable_bit &&
								((sleep_kind_field == KIND_PWR_SAVE) ||
								 (sleep_kind_field == KIND_EXT_STBY));
							next_r.timer_osc_run = next_r.clk_run[G_CRYSTAL];
							next_r.osc_run       = is_standby(sleep_kind_field);
						end
					endcase
				end
			end
			ST_SLEEP: begin
				// Processor and memory clocks stay stopped, so their contents hold
				next_r.clk_run[G_CPU]   = 1'b0;
				next_r.clk_run[G_FLASH] = 1'b0;
				if (any_reset) begin
					next_r.st       = ST_START;
					next_r.by_reset = 1'b1;
				end else if (wake_hit) begin
					next_r.st       = ST_START;
					next_r.by_reset = 1'b0;
				end
				if (any_reset || wake_hit) begin
					next_r.osc_run = 1'b1;
					// Standby kinds have the oscillator already running
					next_r.cnt = is_standby(r.kind) ? (STBY_WAKE_CYC - HALT_EXTRA_CYC)
					                                : START_UP_CYC;
				end
			end
			ST_START: begin
				// A reset that lands while the clocks restart still wins over the interrupt
				if (any_reset) begin
					next_r.by_reset = 1'b1;
				end
				if (r.cnt <= 8'h01) begin
					next_r.st      = ST_HALT;
					next_r.clk_run = '1;
					next_r.timer_osc_run = async_timer_enable_bit;
					next_r.cnt     = HALT_EXTRA_CYC;
				end else begin
					next_r.cnt = r.cnt - 8'h01;
				end
			end
			ST_HALT: begin
				if (any_reset) begin
					next_r.by_reset = 1'b1;
				end
				// The handler or the reset vector is signalled once the hold cycles have run
				if (r.cnt <= 8'h01) begin
					next_r.st           = ST_RUN;
					next_r.core_hold    = 1'b0;
					next_r.asleep       = 1'b0;
					next_r.irq_go       = ~(r.by_reset | any_reset);
					next_r.reset_vector = r.by_reset | any_reset;
				end else begin
					next_r.cnt = r.cnt - 8'h01;
				end
			end
			default: begin
				next_r.st = ST_RUN;
			end
		endcase
		next_r.comparator_on = next_r.comparator_on & ~comparator_off_bit;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Reset leaves every clock and the oscillator running so the core can fetch at once
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r               <= '0;
			r.st            <= ST_RUN;
			r.clk_run       <= '1;
			r.osc_run       <= 1'b1;
			r.comparator_on <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign clk_run       = r.clk_run;
	assign osc_run       = r.osc_run;
	assign timer_osc_run = r.timer_osc_run;
	assign comparator_on = r.comparator_on;
	assign conv_start    = r.conv_start;
	assign core_hold     = r.core_hold;
	assign irq_go        = r.irq_go;
	assign reset_vector  = r.reset_vector;
	assign asleep        = r.asleep;
	assign active_kind   = r.kind;

endmodule // smc_sleep_ctrl

/* rtl/smc_wake_filter.sv */
// Wake source qualifier for the selected sleep kind
`timescale 1ns/1ns
module smc_wake_filter (
	input  wire logic [2:0]                  sleep_kind_field,
	input  wire logic                        async_timer_enable_bit,
	input  wire logic                        comparator_off_bit,
	input  wire logic [smc_pkg::WAKE_W-1:0] wake_req,
	output logic                             wake_hit
);
	import smc_pkg::*;

	logic [WAKE_W-1:0] allow;

	always_comb begin
		allow = '0;
		// External pins outside Idle: line two and levels only
		allow[WK_LINE0_LVL] = 1'b1;
		allow[WK_LINE1_LVL] = 1'b1;
		allow[WK_LINE2]     = 1'b1;
		allow[WK_TWO_WIRE]  = 1'b1;
		case (sleep_kind_field)
			KIND_IDLE: begin
				allow = '1;
				allow[WK_COMPARATOR] = ~comparator_off_bit;
			end
			KIND_QUIET: begin
				allow[WK_TIMER_TWO] = 1'b1;
				allow[WK_SELF_PROG] = 1'b1;
				allow[WK_CONVERTER] = 1'b1;
			end
			KIND_PWR_SAVE, KIND_EXT_STBY: begin
				allow[WK_TIMER_TWO] = async_timer_enable_bit;
			end
			default: begin
				allow[WK_TIMER_TWO] = 1'b0;
			end
		endcase
		wake_hit = |(allow & wake_req);
	end

endmodule // smc_wake_filter

/* test/smc_sleep_sva.sv */
// Concurrent checks on the sleep-mode controller ports
`timescale 1ns/1ns
module smc_sleep_sva #(
	parameter logic [7:0] START_UP_CYC = 8'h06
) (
	input wire logic                        mclk,
	input wire logic                        rst_n,
	input wire logic                        sleep_permit_bit,
	input wire logic [2:0]                  sleep_kind_field,
	input wire logic                        comparator_off_bit,
	input wire logic                        async_timer_enable_bit,
	input wire logic                        crystal_source,
	input wire logic                        converter_enable,
	input wire logic                        halt_instr,
	input wire logic                        any_reset,
	input wire logic [smc_pkg::WAKE_W-1:0] wake_req,
	input wire logic [smc_pkg::GATE_W-1:0] clk_run,
	input wire logic                        osc_run,
	input wire logic                        timer_osc_run,
	input wire logic                        comparator_on,
	input wire logic                        conv_start,
	input wire logic                        core_hold,
	input wire logic                        irq_go,
	input wire logic                        reset_vector,
	input wire logic                        asleep,
	input wire logic [2:0]                  active_kind
);
	import smc_pkg::*;
	localparam int WAKE_MAX = int'(START_UP_CYC) + 6;
	logic go;
	assign go = halt_instr & sleep_permit_bit & ~asleep;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	idle_entry_a: assert property (go && sleep_kind_field == KIND_IDLE |=> asleep && core_hold && clk_run == 5'h1C)
		else $error("idle entry gating wrong");
	quiet_entry_a: assert property (go && sleep_kind_field == KIND_QUIET |=> clk_run == 5'h18 && osc_run)
		else $error("quiet entry gating wrong");
	halt_ignored_a: assert property (halt_instr && !sleep_permit_bit && !asleep |=> !asleep)
		else $error("halt taken without permit");
	conv_kick_a: assert property (go && converter_enable && sleep_kind_field <= 3'h1 |=> conv_start ##1 !conv_start)
		else $error("conversion start missing");
	hold_four_a: assert property (asleep && $rose(clk_run == 5'h1F) |->
		(core_hold && asleep)[*4] ##1 (!core_hold && (irq_go || reset_vector))) else $error("four cycle hold wrong");
	stby_fast_a: assert property (asleep && active_kind[2:1] == 2'b11 && clk_run != 5'h1F && !any_reset &&
		(wake_req & 10'h03A) != 10'h000 |-> ##[1:7] (irq_go || reset_vector)) else $error("standby wake too slow");
	pdown_deaf_a: assert property (asleep && active_kind == KIND_PWR_DOWN && !osc_run && !any_reset &&
		(wake_req & 10'h3C5) == wake_req |=> !osc_run) else $error("power-down woke on blocked source");
	psave_async_a: assert property (asleep && active_kind == KIND_PWR_SAVE && clk_run != 5'h1F |->
		timer_osc_run == async_timer_enable_bit && clk_run[G_CRYSTAL] == async_timer_enable_bit)
		else $error("power-save timer clock wrong");
	comp_off_a: assert property (!asleep && comparator_off_bit |=> !comparator_on)
		else $error("comparator still powered");
	reset_wake_a: assert property (asleep && any_reset && clk_run != 5'h1F |-> ##[1:WAKE_MAX] reset_vector)
		else $error("reset during sleep not honoured");
endmodule // smc_sleep_sva
bind smc_sleep_ctrl smc_sleep_sva #(.START_UP_CYC(START_UP_CYC)) u_sva (.mclk(mclk), .rst_n(rst_n),
	.sleep_permit_bit(sleep_permit_bit), .sleep_kind_field(sleep_kind_field), .comparator_off_bit(comparator_off_bit),
	.async_timer_enable_bit(async_timer_enable_bit), .crystal_source(crystal_source), .any_reset(any_reset),
	.converter_enable(converter_enable), .halt_instr(halt_instr), .wake_req(wake_req), .clk_run(clk_run),
	.osc_run(osc_run), .timer_osc_run(timer_osc_run), .comparator_on(comparator_on), .conv_start(conv_start),
	.core_hold(core_hold), .irq_go(irq_go), .reset_vector(reset_vector), .asleep(asleep), .active_kind(active_kind));

/* test/test_smc_sleep_ctrl.sv */
// Self-checking testbench for the sleep-mode controller
`timescale 1ns/1ns
module test_smc_sleep_ctrl;
	import smc_pkg::*;
	localparam logic [7:0] SU = 8'h03;
	logic              mclk = 1'b0;
	logic              rst_n = 1'b0;
	logic              perm = 1'b0;
	logic [2:0]        kind = 3'h0;
	logic              coff = 1'b0;
	logic              asy = 1'b0;
	logic              xtal = 1'b0;
	logic              halt = 1'b0;
	logic              any_rst = 1'b0;
	logic              cen = 1'b1;
	logic [WAKE_W-1:0] wake = '0;
	logic [GATE_W-1:0] clk_run;
	logic [2:0]        act;
	logic              osc, tosc, comp_on, conv, hold, irq, rvec, asleep;
	int                fails = 0;
	int                total_checks = 0;
	smc_sleep_ctrl #(.START_UP_CYC(SU)) dut (.mclk(mclk), .rst_n(rst_n), .sleep_permit_bit(perm),
		.sleep_kind_field(kind), .comparator_off_bit(coff), .async_timer_enable_bit(asy), .crystal_source(xtal),
		.converter_enable(cen), .halt_instr(halt), .any_reset(any_rst), .wake_req(wake), .clk_run(clk_run),
		.osc_run(osc), .timer_osc_run(tosc), .comparator_on(comp_on), .conv_start(conv), .core_hold(hold),
		.irq_go(irq), .reset_vector(rvec), .asleep(asleep), .active_kind(act));
	always #50 mclk = ~mclk;
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Settings and the halt pulse land on one edge, as software would leave them
	task automatic enter(input logic [2:0] k, input logic a, input logic c, input logic x, input logic p);
		@(posedge mclk);
		kind <= k;
		asy <= a;
		coff <= c;
		xtal <= x;
		perm <= p;
		halt <= 1'b1;
		@(posedge mclk);
		halt <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic run_case(input logic [2:0] k, input logic a, input logic c, input logic x, input logic [4:0] ck,
		input logic o, input logic t, input int bad, input int good);
		int n;
		int lo;
		enter(k, a, c, x, 1'b1);
		chk({asleep, hold, clk_run}, {2'b11, ck});
		chk({osc, tosc, conv, comp_on}, {o, t, k <= 3'h1 && cen, k == 3'h0 && !c});
		chk(act, k);
		@(posedge mclk);
		wake[bad] <= 1'b1;
		repeat (10) @(posedge mclk);
		wake <= '0;
		@(negedge mclk);
		chk({asleep, clk_run}, {1'b1, ck});
		@(posedge mclk);
		wake[good] <= 1'b1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (irq !== 1'b1 && n < 60);
		lo = (k[2:1] == 2'b11) ? int'(STBY_WAKE_CYC) : int'(SU) + int'(HALT_EXTRA_CYC);
		// Plus one edge to take the request and one to the negedge after irq_go rises
		chk(10'(n), 10'(lo + 2));
		chk({asleep, hold, clk_run, rvec}, {2'b00, 5'h1F, 1'b0});
		@(posedge mclk);
		wake <= '0;
		$display("Sleep kind %0h test done", k);
	endtask
	initial begin
		repeat (3000) @(posedge mclk);
		fails++;
		stop_test();
	end
	initial begin
		int n;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk({clk_run, osc, comp_on, asleep, hold}, 9'h1FC);
		enter(KIND_IDLE, 1'b0, 1'b0, 1'b0, 1'b0);
		chk({asleep, clk_run}, 6'h1F);
		enter(KIND_STANDBY, 1'b0, 1'b0, 1'b0, 1'b1);
		chk({asleep, clk_run}, 6'h1F);
		$display("Refused halt test done");
		run_case(KIND_IDLE, 1'b0, 1'b1, 1'b0, 5'h1C, 1'b1, 1'b0, WK_COMPARATOR, WK_LINE0_EDGE);
		run_case(KIND_QUIET, 1'b0, 1'b0, 1'b0, 5'h18, 1'b1, 1'b0, WK_LINE0_EDGE, WK_CONVERTER);
		run_case(KIND_PWR_DOWN, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0, WK_TIMER_TWO, WK_TWO_WIRE);
		run_case(KIND_PWR_SAVE, 1'b1, 1'b0, 1'b0, 5'h10, 1'b0, 1'b1, WK_LINE1_EDGE, WK_TIMER_TWO);
		run_case(KIND_PWR_SAVE, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0, WK_TIMER_TWO, WK_LINE1_LVL);
		run_case(KIND_STANDBY, 1'b0, 1'b0, 1'b1, 5'h00, 1'b1, 1'b0, WK_SELF_PROG, WK_LINE2);
		run_case(KIND_EXT_STBY, 1'b1, 1'b0, 1'b1, 5'h10, 1'b1, 1'b1, WK_LINE0_EDGE, WK_TIMER_TWO);
		cen <= 1'b0;
		run_case(KIND_QUIET, 1'b0, 1'b0, 1'b0, 5'h18, 1'b1, 1'b0, WK_COMPARATOR, WK_SELF_PROG);
		enter(KIND_PWR_DOWN, 1'b0, 1'b0, 1'b0, 1'b1);
		@(posedge mclk);
		any_rst <= 1'b1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (rvec !== 1'b1 && n < 60);
		chk({rvec, irq, asleep}, 3'h4);
		@(posedge mclk);
		any_rst <= 1'b0;
		$display("Reset wake test done");
		stop_test();
	end
endmodule // test_smc_sleep_ctrl
